//--- core/kbd_defs.svh
// register map, field positions, reset values and counter codes for the keyboard port
`ifndef KBD_DEFS_SVH
`define KBD_DEFS_SVH

// ----------------------------------------------------------------
// register bus
// ----------------------------------------------------------------
`define KBD_ADDR_W            2
`define KBD_DATA_W            8
`define KBD_OFS_HIGH          2'h0
`define KBD_OFS_LOW           2'h1
`define KBD_OFS_BUF           2'h2
`define KBD_RD_UNMAPPED       8'h00

// ----------------------------------------------------------------
// status/control high fields
// ----------------------------------------------------------------
`define KBD_H_MASTER_EN       7
`define KBD_H_CLK_MON         6
`define KBD_H_DAT_MON         5
`define KBD_H_FSEL            4
`define KBD_H_IRQ_EN          3
`define KBD_H_FULL            2
`define KBD_H_PERR            1
`define KBD_H_STOP            0

// ----------------------------------------------------------------
// control low fields
// ----------------------------------------------------------------
`define KBD_L_LOAD_EN         7
`define KBD_L_CLK_DRV         6
`define KBD_L_DAT_DRV         5
`define KBD_L_RSVD            4
`define KBD_L_CNT_HI          3
`define KBD_L_CNT_LO          0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define KBD_RST_MASTER_EN     1'b0
`define KBD_RST_FSEL          1'b1
`define KBD_RST_IRQ_EN        1'b0
`define KBD_RST_FLAG          1'b0
`define KBD_RST_LOAD_EN       1'b0
`define KBD_RST_CLK_DRV       1'b1
`define KBD_RST_DAT_DRV       1'b1
`define KBD_RSVD_READ         1'b1
`define KBD_RST_BUF           8'h00
`define KBD_LINE_IDLE         1'b1
`define KBD_PIN_LOW           1'b0

// ----------------------------------------------------------------
// receive counter codes
// ----------------------------------------------------------------
`define KBD_CNT_W             4
`define KBD_CNT_IDLE          4'h0
`define KBD_CNT_ONE           4'h1
`define KBD_CNT_START         4'h1
`define KBD_CNT_D0            4'h2
`define KBD_CNT_D7            4'h9
`define KBD_CNT_PARITY        4'ha
`define KBD_PARITY_OK         1'b1

`endif

//--- core/kbd_pkg.sv
// types shared by the keyboard port status/control logic
package kbd_pkg;

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  typedef struct packed {
    logic master_en;
    logic clk_mon;
    logic dat_mon;
    logic fsel;
    logic irq_en;
    logic full;
    logic perr;
    logic stop;
  } kbd_high_s;

  typedef struct packed {
    logic       load_en;
    logic       clk_drv;
    logic       dat_drv;
    logic       rsvd;
    logic [3:0] cnt;
  } kbd_low_s;

  // ----------------------------------------------------------------
  // register bus request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } kbd_bus_s;

  typedef logic [3:0] rx_count_t;

endpackage : kbd_pkg

//--- core/ps2_line_sync.sv
// two-flop synchronisers and falling-edge detection for the clock and data lines
`timescale 1ns/10ps
`include "kbd_defs.svh"

module ps2_line_sync (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // raw lines from the pins
  input  wire logic [1:0] line_in,
  // when low the lines read as idle
  input  wire logic       enable,
  // synchronised levels and falling edges
  output logic      [1:0] level,
  output logic      [1:0] fall
);

  genvar g;

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_line
      logic meta_reg;
      logic sync_reg;
      logic lvl_reg;
      logic lvl_next;

      // gating sits after the second flop so the first stays clean
      assign lvl_next = enable ? sync_reg : `KBD_LINE_IDLE;

      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg <= `KBD_LINE_IDLE;
          sync_reg <= `KBD_LINE_IDLE;
          lvl_reg  <= `KBD_LINE_IDLE;
        end else begin
          meta_reg <= line_in[g];
          sync_reg <= meta_reg;
          lvl_reg  <= lvl_next;
        end
      end

      assign level[g] = lvl_reg;
      // enabling with the pin already low yields a fall
      assign fall[g]  = lvl_reg & ~lvl_next;
    end
  endgenerate

endmodule : ps2_line_sync

//--- core/ps2_receive_status_control.sv
// status, control and receive counter logic for one keyboard port channel
`timescale 1ns/10ps
`include "kbd_defs.svh"

// Summary of operation
// RQ1 - interrupt enable bit gates CPU requests
// RQ2 - full flag set on good frame loaded
// RQ3 - select zero: flag set on clock fall
// RQ4 - full flag cleared by read-one, write-zero
// RQ5 - parity error flag set on odd-parity failure
// RQ6 - parity flag cleared by read-one, write-zero
// RQ7 - read-only bit holds received stop level
// RQ8 - load enable bit permits buffer loading
// RQ9 - clock drive bit sets clock pin level
// RQ10 - data drive bit sets data pin level
// RQ11 - reserved low bit reads one always
// RQ12 - counter counts clock falls, read-only
// RQ13 - counter cleared by reset, load-enable zero
// RQ14 - counter returns to zero after stop
// RQ15 - counter value names the bit received
// RQ16 - keyboard sends start, data, parity, stop
// RQ17 - select bit chooses flag meaning
// RQ18 - master enable hands pins to controller
// RQ19 - request while flag and enable both set
// RQ20 - frame good when nine bits odd
module ps2_receive_status_control
  import kbd_pkg::*;
(
  // clock and reset
  input  wire logic                      MCLK,
  input  wire logic                      RST_B,
  // register port
  input  wire logic [`KBD_ADDR_W-1:0]    ADDR,
  input  wire logic [`KBD_DATA_W-1:0]    WDATA,
  input  wire logic                      WR,
  input  wire logic                      RD,
  output logic      [`KBD_DATA_W-1:0]    RDATA,
  // interrupt request to the cpu
  output logic                           IRQ,
  // link clock pin, open drain
  input  wire logic                      LINK_CLOCK_LINE_IN,
  output logic                           LINK_CLOCK_LINE_OUT,
  output logic                           LINK_CLOCK_LINE_OE,
  // link data pin, open drain
  input  wire logic                      KD_IN,
  output logic                           KD_OUT,
  output logic                           KD_OE
);

  import kbd_pkg::*;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_data_bit(input rx_count_t c);
    is_data_bit = (c >= `KBD_CNT_D0) && (c <= `KBD_CNT_D7);
  endfunction : is_data_bit

  function automatic logic parity_counted(input rx_count_t c);
    parity_counted = is_data_bit(c) || (c == `KBD_CNT_PARITY);
  endfunction : parity_counted

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  kbd_bus_s              bus;
  logic                  master_en_reg;
  logic                  fsel_reg;
  logic                  irq_en_reg;
  logic                  full_reg;
  logic                  full_next;
  logic                  perr_reg;
  logic                  perr_next;
  logic                  stop_reg;
  logic                  load_en_reg;
  logic                  clk_drv_reg;
  logic                  dat_drv_reg;
  rx_count_t             cnt_reg;
  rx_count_t             cnt_next;
  logic [7:0]            shift_reg;
  logic [7:0]            buf_reg;
  logic                  par_reg;
  logic                  full_armed_reg;
  logic                  perr_armed_reg;
  logic [7:0]            rdata_reg;
  logic                  irq_reg;
  logic                  clk_oe_reg;
  logic                  dat_oe_reg;
  logic [1:0]            line_lvl;
  logic [1:0]            line_fall;
  kbd_high_s             high_img;
  kbd_low_s              low_img;

  assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

  // ----------------------------------------------------------------
  // line synchronisers
  // ----------------------------------------------------------------
  // RQ18 lines read idle while disabled
  ps2_line_sync u_sync (
    .clk     (MCLK),
    .rst_b   (RST_B),
    .line_in ({KD_IN, LINK_CLOCK_LINE_IN}),
    .enable  (master_en_reg),
    .level   (line_lvl),
    .fall    (line_fall)
  );

  wire clk_lvl  = line_lvl[0];
  wire dat_lvl  = line_lvl[1];
  wire clk_fall = line_fall[0];

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_high = bus.wr && (bus.addr == `KBD_OFS_HIGH);
  wire wr_low  = bus.wr && (bus.addr == `KBD_OFS_LOW);
  wire rd_high = bus.rd && (bus.addr == `KBD_OFS_HIGH);
  wire rd_low  = bus.rd && (bus.addr == `KBD_OFS_LOW);
  wire rd_buf  = bus.rd && (bus.addr == `KBD_OFS_BUF);

  // ----------------------------------------------------------------
  // receive sequencing
  // ----------------------------------------------------------------
  // RQ12 count only while enabled for reception
  wire       counting   = master_en_reg && load_en_reg;
  wire       rx_fall    = counting && clk_fall;
  // RQ16 eleventh fall carries the stop bit
  wire       at_stop    = rx_fall && (cnt_reg == `KBD_CNT_PARITY);
  // RQ15 value after the fall names the bit just taken
  wire [3:0] cnt_inc    = cnt_reg + `KBD_CNT_ONE;
  wire       take_data  = rx_fall && is_data_bit(cnt_inc);
  wire       take_par   = rx_fall && parity_counted(cnt_inc);
  wire       frame_good = (par_reg == `KBD_PARITY_OK);
  wire       frame_done = at_stop;
  // RQ13 write of zero to load enable clears counter
  wire       cnt_clear  = (wr_low && !bus.wdata[`KBD_L_LOAD_EN]) || !master_en_reg;

  always_comb begin
    cnt_next = cnt_reg;
    if (cnt_clear) begin
      cnt_next = `KBD_CNT_IDLE;
    end else if (at_stop) begin
      // RQ14 back to idle after the stop bit
      cnt_next = `KBD_CNT_IDLE;
    end else if (rx_fall) begin
      // RQ12 advance on each clock fall
      cnt_next = cnt_inc;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_reg   <= `KBD_CNT_IDLE;
      shift_reg <= `KBD_RST_BUF;
      par_reg   <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      if (rx_fall && (cnt_inc == `KBD_CNT_START)) begin
        par_reg <= 1'b0;
      end else if (take_par) begin
        // RQ20 running parity over data and parity bits
        par_reg <= par_reg ^ dat_lvl;
      end
      if (take_data) begin
        // lsb arrives first so shift toward bit 0
        shift_reg <= {dat_lvl, shift_reg[7:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // receive buffer and stop status
  // ----------------------------------------------------------------
  // RQ8 load only when permitted
  wire load_buf = frame_done && frame_good && load_en_reg;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      buf_reg  <= `KBD_RST_BUF;
      stop_reg <= `KBD_RST_FLAG;
    end else if (!master_en_reg) begin
      buf_reg  <= `KBD_RST_BUF;
    end else if (load_buf) begin
      buf_reg  <= shift_reg;
      // RQ7 latch the stop level with the byte
      stop_reg <= dat_lvl;
    end
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  // RQ2 good frame loaded while select is one
  wire full_set_rx  = fsel_reg && load_buf;
  // RQ3 any clock fall while select is zero
  wire full_set_clk = !fsel_reg && clk_fall;
  wire full_set     = full_set_rx || full_set_clk;
  // RQ5 odd parity failure
  wire perr_set     = frame_done && !frame_good;
  // RQ4 clear only after reading one, writing 1 ignored
  wire full_clr     = wr_high && full_armed_reg && !bus.wdata[`KBD_H_FULL];
  // RQ6 same clearing discipline for parity
  wire perr_clr     = wr_high && perr_armed_reg && !bus.wdata[`KBD_H_PERR];

  // a new event in the clearing cycle is kept
  assign full_next = full_set || (full_reg && !full_clr);
  assign perr_next = perr_set || (perr_reg && !perr_clr);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      full_reg       <= `KBD_RST_FLAG;
      perr_reg       <= `KBD_RST_FLAG;
      full_armed_reg <= 1'b0;
      perr_armed_reg <= 1'b0;
    end else begin
      full_reg <= full_next;
      perr_reg <= perr_next;
      if (rd_high) begin
        full_armed_reg <= full_reg;
        perr_armed_reg <= perr_reg;
      end else if (wr_high) begin
        full_armed_reg <= 1'b0;
        perr_armed_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      master_en_reg <= `KBD_RST_MASTER_EN;
      fsel_reg      <= `KBD_RST_FSEL;
      irq_en_reg    <= `KBD_RST_IRQ_EN;
      load_en_reg   <= `KBD_RST_LOAD_EN;
      clk_drv_reg   <= `KBD_RST_CLK_DRV;
      dat_drv_reg   <= `KBD_RST_DAT_DRV;
    end else begin
      if (wr_high) begin
        // RQ18 master enable
        master_en_reg <= bus.wdata[`KBD_H_MASTER_EN];
        // RQ17 flag meaning select
        fsel_reg      <= bus.wdata[`KBD_H_FSEL];
        irq_en_reg    <= bus.wdata[`KBD_H_IRQ_EN];
      end
      if (wr_low) begin
        load_en_reg <= bus.wdata[`KBD_L_LOAD_EN];
        clk_drv_reg <= bus.wdata[`KBD_L_CLK_DRV];
        dat_drv_reg <= bus.wdata[`KBD_L_DAT_DRV];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  assign high_img = '{master_en: master_en_reg, clk_mon: clk_lvl, dat_mon: dat_lvl,
                      fsel: fsel_reg, irq_en: irq_en_reg, full: full_reg,
                      perr: perr_reg, stop: stop_reg};
  // RQ11 reserved bit reads one
  assign low_img  = '{load_en: load_en_reg, clk_drv: clk_drv_reg, dat_drv: dat_drv_reg,
                      rsvd: `KBD_RSVD_READ, cnt: cnt_reg};

  wire [7:0] rd_mux = rd_high ? high_img :
                      rd_low  ? low_img  :
                      rd_buf  ? buf_reg  : `KBD_RD_UNMAPPED;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_reg <= `KBD_RD_UNMAPPED;
    end else begin
      rdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // interrupt and pin drive
  // ----------------------------------------------------------------
  // RQ19 request follows flag and enable
  // RQ1 enable bit gates the request
  wire irq_next = full_next && irq_en_reg;

  // RQ9 low pulls the clock pin, high releases it
  // with select one, a set full flag also holds the clock low so the keyboard waits
  wire clk_low  = master_en_reg && (!clk_drv_reg || (fsel_reg && full_reg));
  // RQ10 low drives the data pin, high releases it
  wire dat_low  = master_en_reg && !dat_drv_reg;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_reg    <= 1'b0;
      clk_oe_reg <= 1'b0;
      dat_oe_reg <= 1'b0;
    end else begin
      irq_reg    <= irq_next;
      clk_oe_reg <= clk_low;
      dat_oe_reg <= dat_low;
    end
  end

  // open drain: the driven value is always low
  logic pin_low_reg;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_low_reg <= `KBD_PIN_LOW;
    end else begin
      pin_low_reg <= `KBD_PIN_LOW;
    end
  end

  assign RDATA    = rdata_reg;
  assign IRQ      = irq_reg;
  assign LINK_CLOCK_LINE_OUT = pin_low_reg;
  assign LINK_CLOCK_LINE_OE  = clk_oe_reg;
  assign KD_OUT   = pin_low_reg;
  assign KD_OE    = dat_oe_reg;

endmodule : ps2_receive_status_control

//--- test/ps2_kbd_model.sv
// behavioural keyboard driving the link clock and data lines
`timescale 1ns/10ps

module ps2_kbd_model (
  // resolved clock line, seen to honour a host inhibit
  input  wire logic line_clk,
  // 1 releases the line, pull-ups then make it high
  output logic      link_clock_line_o,
  output logic      kd_o
);
  initial begin
    link_clock_line_o = 1'b1;
    kd_o   = 1'b1;
  end

  // one bit per clock, data valid while clock low
  task automatic send_bit(input logic b);
    wait (line_clk === 1'b1);
    #20 kd_o = b;
    #42.5 link_clock_line_o = 1'b0;
    #62.5 link_clock_line_o = 1'b1;
  endtask : send_bit

  // data released after the stop bit
  task automatic release_data;
    #20 kd_o = 1'b1;
  endtask : release_data
endmodule : ps2_kbd_model

//--- test/ps2_receive_status_control_checker.sv
// concurrent checks on the register port and pins of the keyboard port
`timescale 1ns/10ps
`include "kbd_defs.svh"

module ps2_receive_status_control_checker (
  // clock and reset
  input wire logic       MCLK,
  input wire logic       RST_B,
  // register port
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  // cpu request and pins
  input wire logic       IRQ,
  input wire logic       LINK_CLOCK_LINE_IN,
  input wire logic       LINK_CLOCK_LINE_OUT,
  input wire logic       LINK_CLOCK_LINE_OE,
  input wire logic       KD_IN,
  input wire logic       KD_OUT,
  input wire logic       KD_OE
);
  // shadow of master enable, pins are only ours while it is set
  logic men_reg;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      men_reg <= 1'b0;
    end else if (WR && ADDR == 2'h0) begin
      men_reg <= WDATA[7];
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence rd_high;
    RD && ADDR == 2'h0;
  endsequence
  // read a flag as one, write it, read again
  sequence rmw(int b, bit v);
    rd_high ##1 (RDATA[b] && WR && ADDR == 2'h0 && WDATA[b] == v) ##1 rd_high;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_full_write_one: assert property (rmw(2, 1'b1) |=> RDATA[2])
    else $error("full flag changed by a write of one");
  a_full_clear: assert property (rmw(2, 1'b0) |=> !RDATA[2])
    else $error("full flag not cleared");
  a_perr_write_one: assert property (rmw(1, 1'b1) |=> RDATA[1])
    else $error("parity flag changed by a write of one");
  a_perr_clear: assert property (rmw(1, 1'b0) |=> !RDATA[1])
    else $error("parity flag not cleared");
  a_read_gap_zero: assert property (!RD |=> RDATA == 8'h00)
    else $error("read data outside the read slot");
  a_rsvd_reads_one: assert property (RD && ADDR == 2'h1 |=> RDATA[4])
    else $error("reserved bit read as zero");
  a_count_in_range: assert property (RD && ADDR == 2'h1 |=> RDATA[3:0] <= 4'ha)
    else $error("receive counter beyond parity code");
  a_count_cleared: assert property ((WR && ADDR == 2'h1 && !WDATA[7]) ##1 (RD && ADDR == 2'h1)
    |=> RDATA[3:0] == 4'h0)
    else $error("counter not zeroed by load disable");
  a_irq_follows_flags: assert property (rd_high |=> IRQ == (RDATA[3] && RDATA[2]))
    else $error("request does not match flag and enable");
  a_data_drive: assert property ((WR && ADDR == 2'h1 && men_reg) ##1 !WR |=> KD_OE == !$past(WDATA[5], 2))
    else $error("data pin drive wrong");
  a_clock_pull: assert property ((WR && ADDR == 2'h1 && men_reg && !WDATA[6]) ##1 !WR |=> LINK_CLOCK_LINE_OE)
    else $error("clock pin not pulled low");
  a_pins_released: assert property (!men_reg && !$past(men_reg) && !$past(men_reg, 2) |-> !LINK_CLOCK_LINE_OE && !KD_OE)
    else $error("pins driven while disabled");
  a_open_drain_low: assert property (LINK_CLOCK_LINE_OUT == 1'b0 && KD_OUT == 1'b0)
    else $error("pin drive value not low");
endmodule : ps2_receive_status_control_checker

bind ps2_receive_status_control ps2_receive_status_control_checker chk (
  .MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
  .LINK_CLOCK_LINE_IN(LINK_CLOCK_LINE_IN), .LINK_CLOCK_LINE_OUT(LINK_CLOCK_LINE_OUT), .LINK_CLOCK_LINE_OE(LINK_CLOCK_LINE_OE), .KD_IN(KD_IN), .KD_OUT(KD_OUT), .KD_OE(KD_OE)
);

//--- test/ps2_receive_status_control_tb.sv
// self-checking bench for the keyboard port status/control block
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, a); end end

module ps2_receive_status_control_tb;
  logic       MCLK, RST_B, WR, RD, IRQ;
  logic [1:0] ADDR;
  logic [7:0] WDATA, RDATA, d;
  logic       LINK_CLOCK_LINE_OUT, LINK_CLOCK_LINE_OE, KD_OUT, KD_OE;
  logic       link_clock_line_o, kd_o, link_clock_line_line, kd_line;
  int         num_errors, checked;

  // open drain lines with pull-ups
  assign link_clock_line_line = link_clock_line_o & ~(LINK_CLOCK_LINE_OE & ~LINK_CLOCK_LINE_OUT);
  assign kd_line   = kd_o & ~(KD_OE & ~KD_OUT);

  ps2_receive_status_control dut (
    .MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
    .LINK_CLOCK_LINE_IN(link_clock_line_line), .LINK_CLOCK_LINE_OUT(LINK_CLOCK_LINE_OUT), .LINK_CLOCK_LINE_OE(LINK_CLOCK_LINE_OE),
    .KD_IN(kd_line), .KD_OUT(KD_OUT), .KD_OE(KD_OE)
  );
  ps2_kbd_model kbd (.line_clk(link_clock_line_line), .link_clock_line_o(link_clock_line_o), .kd_o(kd_o));

  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  // ----------------------------------------------------------------
  // bus tasks, entered just after a rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    ADDR <= a; WDATA <= v; WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    ADDR <= a; RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask : rd
  task automatic rchk(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    logic [7:0] v;
    rd(a, v);
    `CHK(n, e, v & m)
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : idle
  // frame bits go out lsb first, counter checked after every fall
  task automatic frame(input logic [7:0] b, input logic bad, input logic stop, input int nb, input logic on);
    logic [10:0] bits;
    bits = {stop, (~^b) ^ bad, b, 1'b0};
    for (int i = 0; i < nb; i++) begin
      kbd.send_bit(bits[i]);
      idle(1);
      rchk(2'h1, 8'h0f, on ? 8'((i + 1) % 11) : 8'h00, "count");
    end
    kbd.release_data();
  endtask : frame

  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    RST_B = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 2'h0; WDATA = 8'h00; num_errors = 0; checked = 0;
    repeat (12) @(posedge MCLK);
    RST_B <= 1'b1;
    idle(1);
    rchk(2'h0, 8'hff, 8'h70, "high reset");
    rchk(2'h1, 8'hff, 8'h70, "low reset");
    rchk(2'h3, 8'hff, 8'h00, "unmapped");
    wr(2'h1, 8'h0f);
    rchk(2'h1, 8'hff, 8'h10, "low ro bits");
    `CHK("pins idle", 2'b00, {LINK_CLOCK_LINE_OE, KD_OE})
    wr(2'h0, 8'h98);
    // monitor bits trail the pins by the synchroniser and level flops
    idle(4);
    `CHK("pins pulled", 2'b11, {LINK_CLOCK_LINE_OE, KD_OE})
    rchk(2'h0, 8'h60, 8'h00, "line monitor");
    wr(2'h1, 8'hf0);
    idle(3);
    `CHK("pins free", 2'b00, {LINK_CLOCK_LINE_OE, KD_OE})
    // clock pulled alone from a released state, loading off so no count
    wr(2'h1, 8'h30);
    idle(3);
    `CHK("clock only", 2'b10, {LINK_CLOCK_LINE_OE, KD_OE})
    `CHK("drive low", 2'b00, {LINK_CLOCK_LINE_OUT, KD_OUT})
    wr(2'h1, 8'hf0);
    idle(3);
    // good frame, then flag handling
    frame(8'ha5, 1'b0, 1'b1, 11, 1'b1);
    idle(2);
    rchk(2'h0, 8'hbf, 8'hbd, "frame done");
    `CHK("irq set", 1'b1, IRQ)
    `CHK("clock hold", 1'b1, LINK_CLOCK_LINE_OE)
    rchk(2'h2, 8'hff, 8'ha5, "buffer");
    rd(2'h0, d);
    wr(2'h0, 8'h9c);
    rchk(2'h0, 8'h04, 8'h04, "full kept");
    rd(2'h0, d);
    wr(2'h0, 8'h98);
    rchk(2'h0, 8'h04, 8'h00, "full clear");
    idle(2);
    `CHK("irq drop", 1'b0, IRQ)
    // parity failure
    frame(8'h3c, 1'b1, 1'b1, 11, 1'b1);
    idle(2);
    rchk(2'h0, 8'h06, 8'h02, "parity err");
    rchk(2'h2, 8'hff, 8'ha5, "buffer kept");
    rd(2'h0, d);
    wr(2'h0, 8'h9a);
    rchk(2'h0, 8'h02, 8'h02, "perr kept");
    rd(2'h0, d);
    wr(2'h0, 8'h98);
    rchk(2'h0, 8'h02, 8'h00, "perr clear");
    // stop bit low, request masked
    frame(8'h5a, 1'b0, 1'b0, 11, 1'b1);
    idle(2);
    rchk(2'h0, 8'h07, 8'h04, "stop low");
    rchk(2'h2, 8'hff, 8'h5a, "buffer new");
    wr(2'h0, 8'h90);
    idle(2);
    `CHK("irq masked", 1'b0, IRQ)
    rd(2'h0, d);
    wr(2'h0, 8'h90);
    rchk(2'h0, 8'h04, 8'h00, "full clear 2");
    // abort mid-frame, then receive with loading off
    frame(8'h11, 1'b0, 1'b1, 4, 1'b1);
    wr(2'h1, 8'h70);
    rchk(2'h1, 8'h0f, 8'h00, "count zeroed");
    frame(8'hc3, 1'b0, 1'b1, 11, 1'b0);
    idle(2);
    rchk(2'h0, 8'h04, 8'h00, "no load full");
    rchk(2'h2, 8'hff, 8'h5a, "no load buffer");
    // clock-fall flag mode
    wr(2'h0, 8'h88);
    kbd.send_bit(1'b1);
    idle(3);
    rchk(2'h0, 8'h04, 8'h04, "fall flag");
    `CHK("fall irq", 1'b1, IRQ)
    give_verdict();
  end

  initial begin
    #500000;
    num_errors++;
    give_verdict();
  end
endmodule : ps2_receive_status_control_tb
